// ---- src/rco_pkg.sv ----
package rco_pkg;
	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_CONTROL   = 12'h895;
	localparam logic [11:0] IDX_SOURCE    = 12'h896;
	localparam logic [11:0] IDX_STATUS    = 12'h897;
	// control and source register fields
	localparam int          EN_BIT        = 7;
	localparam int          DUTY_HI       = 4;
	localparam int          DUTY_LO       = 3;
	localparam int          DIV_HI        = 2;
	localparam int          DIV_LO        = 0;
	localparam int          SRC_HI        = 3;
	// status register fields
	localparam int          ST_RUN_BIT    = 0;
	localparam int          ST_WAVE_BIT   = 1;
	localparam int          ST_SRCOK_BIT  = 2;
	// reset values
	localparam logic        EN_RST        = 1'h0;
	localparam logic [1:0]  DUTY_RST      = 2'h2;
	localparam logic [2:0]  DIV_RST       = 3'h0;
	localparam logic [3:0]  SRC_RST       = 4'h0;
	// source codes
	localparam logic [3:0]  SRC_MAIN      = 4'h0;
	localparam logic [3:0]  SRC_LAST      = 4'ha;
	localparam int          NUM_EXT_SRC   = 10;
	// divider and duty encodings
	localparam logic [2:0]  DIV_NONE      = 3'h0;
	localparam logic [1:0]  DUTY_ZERO     = 2'h0;
	// bus constants
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [31:0] RDATA_NONE    = 32'h0000_0000;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_ARM = 2'b01,
		ST_RUN = 2'b10
	} rco_state_e;
endpackage : rco_pkg

// ---- src/rco_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface rco_if;
	logic       base_lvl;
	logic       base_rise;
	logic       base_ok;
	logic       run;
	logic       restart;
	logic [2:0] div;
	logic [1:0] duty;
	logic       wave;

	modport src (output base_lvl, output base_rise, output base_ok);
	modport shp (input base_lvl, input base_rise, input run, input restart, input div, input duty, output wave);
	modport ctl (input base_lvl, input base_rise, input base_ok, input wave,
		output run, output restart, output div, output duty);
endinterface : rco_if
`default_nettype wire

// ---- src/rco_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module rco_source #(
	parameter int NUM_SRC = rco_pkg::NUM_EXT_SRC
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// sources and selection
	input  wire logic [NUM_SRC-1:0] src_clk_in,
	input  wire logic [3:0]         sel,
	input  wire logic               sleep_mode,
	// base clock out
	rco_if.src                      bus
);
	typedef struct packed {
		logic [NUM_SRC-1:0] sync1;
		logic [NUM_SRC-1:0] sync2;
		logic               fosc_tgl;
		logic               lvl;
	} rco_src_s;

	rco_src_s q;
	rco_src_s d;
	logic     sel_lvl;
	logic     ok;

	always_comb begin
		d = q;
		d.sync1 = src_clk_in;
		d.sync2 = q.sync1;
		// main clock cannot be sampled by itself, so it is halved
		d.fosc_tgl = ~q.fosc_tgl;
		ok = (sel <= rco_pkg::SRC_LAST) &&
			!(sleep_mode && sel == rco_pkg::SRC_MAIN);
		if (sel == rco_pkg::SRC_MAIN) begin
			sel_lvl = q.fosc_tgl;
		end else if (ok) begin
			sel_lvl = q.sync2[sel - 4'h1];
		end else begin
			sel_lvl = 1'b0;
		end
		d.lvl = sel_lvl & ok;
		bus.base_ok = ok;
		bus.base_lvl = sel_lvl & ok;
		bus.base_rise = sel_lvl & ok & ~q.lvl;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : rco_source
`default_nettype wire

// ---- src/rco_shaper.sv ----
`timescale 1ns/1ps
`default_nettype none
module rco_shaper (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// base clock and settings
	rco_if.shp        bus
);
	typedef struct packed {
		logic [6:0] cnt;
		logic       wave;
	} rco_shp_s;

	rco_shp_s   q;
	rco_shp_s   d;
	logic [6:0] cnt_now;
	logic [6:0] mask;
	logic [7:0] half;
	logic [8:0] thr;

	always_comb begin
		d = q;
		mask = 7'((8'h01 << bus.div) - 8'h01);
		// live divider change may land past the mask; wrap at once
		if (bus.restart) begin
			cnt_now = 7'h00;
		end else if (bus.base_rise) begin
			cnt_now = (q.cnt >= mask) ? 7'h00 : 7'(q.cnt + 7'h01);
		end else begin
			cnt_now = q.cnt;
		end
		d.cnt = bus.run ? cnt_now : 7'h00;
		// position in half periods of the base clock
		half = {cnt_now, ~bus.base_lvl};
		thr = (9'({7'h00, bus.duty}) << bus.div) >> 1;
		if (!bus.run) begin
			d.wave = 1'b0;
		end else if (bus.div == rco_pkg::DIV_NONE) begin
			d.wave = (bus.duty != rco_pkg::DUTY_ZERO) & bus.base_lvl;
		end else begin
			d.wave = {1'b0, half} < thr;
		end
		bus.wave = q.wave;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : rco_shaper
`default_nettype wire

// ---- src/rco_top.sv ----
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rco_top #(
	parameter int NUM_SRC = rco_pkg::NUM_EXT_SRC
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// ahb-lite slave
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic [31:0]             hrdata,
	output logic                    hresp,
	// clock sources, codes 1 and up
	input  wire logic [NUM_SRC-1:0] src_clk_in,
	// power state
	input  wire logic               sleep_mode,
	// generated clock
	output logic                    reference_clock_output_pin,
	output logic                    ref_clk_internal
);
	typedef struct packed {
		logic                 en;
		logic [1:0]           duty;
		logic [2:0]           div;
		logic [3:0]           src;
		rco_pkg::rco_state_e  state;
		logic                 wr_pend;
		logic                 wr_hit;
		logic [11:0]          wr_idx;
		logic [31:0]          rdata;
	} rco_top_s;

	rco_top_s   q;
	rco_top_s   d;
	logic [1:0] rst_sync_q;
	logic       rst_sync_n;
	logic       take;
	logic       addr_ok;
	logic       go;
	logic       restart;
	logic       run;

	rco_if link ();

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_sync_n = rst_sync_q[1];

	rco_source #(
		.NUM_SRC    (NUM_SRC)
	) u_source (
		.clk        (clk),
		.rst_n      (rst_sync_n),
		.src_clk_in (src_clk_in),
		.sel        (q.src),
		.sleep_mode (sleep_mode),
		.bus        (link.src)
	);

	rco_shaper u_shaper (
		.clk   (clk),
		.rst_n (rst_sync_n),
		.bus   (link.shp)
	);

	// word-aligned decode of the mapped window
	function automatic logic is_mapped(input logic [31:0] a);
		logic [11:0] idx;
		idx = a[13:2];
		is_mapped = (a[31:14] == 18'h00000) && (a[1:0] == 2'h0) &&
			(idx == rco_pkg::IDX_CONTROL || idx == rco_pkg::IDX_SOURCE || idx == rco_pkg::IDX_STATUS);
	endfunction : is_mapped

	always_comb begin
		d = q;
		take = hsel & hready & (htrans == rco_pkg::HTRANS_NONSEQ);
		addr_ok = is_mapped(haddr);

		// data phase of a write; unmapped writes are dropped
		if (q.wr_pend && q.wr_hit) begin
			if (q.wr_idx == rco_pkg::IDX_CONTROL) begin
				d.en = hwdata[rco_pkg::EN_BIT];
				d.duty = hwdata[rco_pkg::DUTY_HI:rco_pkg::DUTY_LO];
				d.div = hwdata[rco_pkg::DIV_HI:rco_pkg::DIV_LO];
			end else if (q.wr_idx == rco_pkg::IDX_SOURCE) begin
				d.src = hwdata[rco_pkg::SRC_HI:0];
			end
		end

		// address phase capture
		d.wr_pend = take & hwrite;
		d.wr_hit = take & hwrite & addr_ok;
		d.wr_idx = take ? haddr[13:2] : q.wr_idx;

		// read data prepared from the updated copy so a write just
		// before a read is seen by it
		if (take && !hwrite) begin
			d.rdata = rco_pkg::RDATA_NONE;
			if (addr_ok && haddr[13:2] == rco_pkg::IDX_CONTROL) begin
				d.rdata[rco_pkg::EN_BIT] = d.en;
				d.rdata[rco_pkg::DUTY_HI:rco_pkg::DUTY_LO] = d.duty;
				d.rdata[rco_pkg::DIV_HI:rco_pkg::DIV_LO] = d.div;
			end else if (addr_ok && haddr[13:2] == rco_pkg::IDX_SOURCE) begin
				d.rdata[rco_pkg::SRC_HI:0] = d.src;
			end else if (addr_ok && haddr[13:2] == rco_pkg::IDX_STATUS) begin
				d.rdata[rco_pkg::ST_RUN_BIT] = (q.state == rco_pkg::ST_RUN);
				d.rdata[rco_pkg::ST_WAVE_BIT] = link.wave;
				d.rdata[rco_pkg::ST_SRCOK_BIT] = link.base_ok;
			end
		end

		// output sequencing
		go = q.en & link.base_ok;
		// start only on a base rising edge so the first high is whole
		restart = (q.state == rco_pkg::ST_ARM) & go & link.base_rise;
		run = go & ((q.state == rco_pkg::ST_RUN) | restart);

		unique case (q.state)
			rco_pkg::ST_OFF: begin
				if (go) begin
					d.state = rco_pkg::ST_ARM;
				end
			end
			rco_pkg::ST_ARM: begin
				if (!go) begin
					d.state = rco_pkg::ST_OFF;
				end else if (link.base_rise) begin
					d.state = rco_pkg::ST_RUN;
				end
			end
			rco_pkg::ST_RUN: begin
				if (!go) begin
					d.state = rco_pkg::ST_OFF;
				end
			end
			default: begin
				d.state = rco_pkg::ST_OFF;
			end
		endcase
	end

	assign link.run = run;
	assign link.restart = restart;
	assign link.div = q.div;
	assign link.duty = q.duty;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			q.en <= rco_pkg::EN_RST;
			q.duty <= rco_pkg::DUTY_RST;
			q.div <= rco_pkg::DIV_RST;
			q.src <= rco_pkg::SRC_RST;
			q.state <= rco_pkg::ST_OFF;
			q.wr_pend <= 1'b0;
			q.wr_hit <= 1'b0;
			q.wr_idx <= 12'h000;
			q.rdata <= rco_pkg::RDATA_NONE;
		end else begin
			q <= d;
		end
	end

	// zero wait states; every access answers okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;

	// same flopped wave to pin and peripherals
	assign reference_clock_output_pin = link.wave;
	assign ref_clk_internal = link.wave;
endmodule : rco_top
`default_nettype wire

// ---- tb/rco_top_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module rco_top_props #(
	parameter int NUM_SRC = 10
) (
	// clock and reset
	input wire logic               clk,
	input wire logic               rst_n,
	// bus
	input wire logic               hsel,
	input wire logic [31:0]        haddr,
	input wire logic [1:0]         htrans,
	input wire logic               hwrite,
	input wire logic [2:0]         hsize,
	input wire logic [31:0]        hwdata,
	input wire logic               hready,
	input wire logic               hreadyout,
	input wire logic [31:0]        hrdata,
	input wire logic               hresp,
	// sources and outputs
	input wire logic [NUM_SRC-1:0] src_clk_in,
	input wire logic               sleep_mode,
	input wire logic               reference_clock_output_pin,
	input wire logic               ref_clk_internal
);
	localparam logic [31:0] A_C = {18'h0, rco_pkg::IDX_CONTROL, 2'h0};
	localparam logic [31:0] A_S = {18'h0, rco_pkg::IDX_SOURCE, 2'h0};
	logic       wc_q, ws_q, rc_q;
	logic [7:0] ctl_q, src_q;
	wire        take = hsel && hready && htrans == rco_pkg::HTRANS_NONSEQ;
	wire        pin  = reference_clock_output_pin;
	// settings the design used when it launched a rise
	wire        rise_ok = ctl_q[7] && ctl_q[4:3] != 2'h0 && src_q < 8'h0b;
	// shadow registers follow the bus so checks need no internal probes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{wc_q, ws_q, rc_q} <= 3'h0;
			ctl_q <= 8'h10;
			src_q <= 8'h00;
		end else begin
			wc_q <= take && hwrite && haddr == A_C;
			ws_q <= take && hwrite && haddr == A_S;
			rc_q <= take && !hwrite && haddr == A_C;
			if (wc_q) ctl_q <= hwdata[7:0] & 8'h9f;
			if (ws_q) src_q <= {4'h0, hwdata[3:0]};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
	chk_pin_mirror: assert property (pin == ref_clk_internal) else $error("outputs differ");
	chk_read_ctl: assert property (rc_q |-> hrdata == {24'h0, ctl_q}) else $error("control read");
	chk_off_low: assert property (!ctl_q[7] [*3] |-> !pin) else $error("output while off");
	chk_rsvd_low: assert property ((src_q >= 8'h0b) [*3] |-> !pin) else $error("reserved runs");
	chk_sleep_main: assert property ((sleep_mode && src_q == 8'h0) [*3] |-> !pin) else $error("sleep main runs");
	chk_rise_cause: assert property ($rose(pin) |-> $past(rise_ok)) else $error("bad rise");
	cover property ($rose(pin));
	cover property (rc_q && hrdata[7]);
	cover property (sleep_mode && $rose(pin));
endmodule : rco_top_props
bind rco_top rco_top_props #(.NUM_SRC(NUM_SRC)) u_props (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hrdata(hrdata), .hresp(hresp), .src_clk_in(src_clk_in), .sleep_mode(sleep_mode),
	.reference_clock_output_pin(reference_clock_output_pin), .ref_clk_internal(ref_clk_internal));
`default_nettype wire

// ---- tb/rco_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rco_src_model #(
	parameter int NUM_SRC = 10
) (
	input  wire logic               clk,
	output var  logic [NUM_SRC-1:0] src_clk
);
	int cnt [NUM_SRC];
	initial src_clk = '0;
	initial foreach (cnt[i]) cnt[i] = 0;
	// locked to clk so measured periods are exact; half period of source i is 3+i cycles
	always @(posedge clk) begin
		for (int i = 0; i < NUM_SRC; i++) begin
			if (cnt[i] == 2 + i) begin
				cnt[i] <= 0;
				src_clk[i] <= ~src_clk[i];
			end else cnt[i] <= cnt[i] + 1;
		end
	end
endmodule : rco_src_model
`default_nettype wire

// ---- tb/tb_rco_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_rco_top;
	localparam logic [31:0] A_C = {18'h0, rco_pkg::IDX_CONTROL, 2'h0};
	localparam logic [31:0] A_S = {18'h0, rco_pkg::IDX_SOURCE, 2'h0};
	localparam logic [31:0] A_T = {18'h0, rco_pkg::IDX_STATUS, 2'h0};
	logic        clk = 0, rst_n = 0, hwrite = 0, sleep_mode = 0;
	logic [1:0]  htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
	logic        hreadyout, hresp, pin, pin_int;
	logic [9:0]  src;
	logic [1:0]  dc;
	int          miscompares = 0, comparisons = 0, cyc = 0, hi, per, n;
	always #10 clk = ~clk;
	rco_src_model u_src (.clk(clk), .src_clk(src));
	rco_top u_dut (.clk(clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.src_clk_in(src), .sleep_mode(sleep_mode), .reference_clock_output_pin(pin), .ref_clk_internal(pin_int));
	task automatic conclude;
		$display("miscompares %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
		haddr <= a;
		hwrite <= w;
		htrans <= rco_pkg::HTRANS_NONSEQ;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		r = hrdata;
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] wd);
		logic [31:0] r;
		bus(1'b1, a, wd, r);
	endtask : wr
	task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(nm, e, r);
	endtask : rdc
	// settled sampling at the falling edge; hands back right after a rising edge
	task automatic meas(output int h, output int p);
		h = 0;
		p = 0;
		@(negedge clk);
		while (pin !== 1'b0) @(negedge clk);
		while (pin !== 1'b1) @(negedge clk);
		while (pin === 1'b1) begin h++; @(negedge clk); end
		while (pin === 1'b0) begin p++; @(negedge clk); end
		p += h;
		@(posedge clk);
	endtask : meas
	task automatic rises(output int k);
		logic p;
		k = 0;
		// settled level first, so a rise launched at the call edge is not counted
		@(negedge clk);
		p = pin;
		repeat (200) begin
			@(negedge clk);
			if (pin === 1'b1 && p !== 1'b1) k++;
			p = pin;
		end
		@(posedge clk);
	endtask : rises
	function automatic int exp_hi(int h, int v, int c);
		if (v == 0) return (c == 0) ? 0 : h;
		return (c * h) << (v - 1);
	endfunction : exp_hi
	initial begin
		void'($urandom(75));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rdc("ctl_reset", A_C, 32'h10);
		rdc("src_reset", A_S, 32'h0);
		repeat (4) begin
			d = $urandom & 32'h7f;
			wr(A_C, d);
			rdc("ctl_fields", A_C, d & 32'h1f);
		end
		wr(A_C + 32'hc, 32'hff);
		rdc("unmapped", A_C + 32'hc, 32'h0);
		wr(A_S, 32'h1);
		rdc("status_off", A_T, 32'h4);
		for (int v = 0; v < 8; v++) begin
			dc = 2'($urandom_range(3, 1));
			wr(A_C, 32'h0);
			wr(A_C, {27'h0, dc, 3'(v)});
			wr(A_C, {24'h0, 1'b1, 2'h0, dc, 3'(v)});
			rdc("ctl_enabled", A_C, {24'h0, 1'b1, 2'h0, dc, 3'(v)});
			meas(hi, per);
			chk("high_time", exp_hi(3, v, dc), hi);
			chk("period", 6 << v, per);
		end
		for (int v = 0; v < 4; v += 3) begin
			wr(A_C, 32'h0);
			wr(A_C, 32'h80 | v);
			rises(n);
			chk("duty_zero", 0, n);
		end
		wr(A_C, 32'h0);
		wr(A_C, 32'h9a);
		meas(hi, per);
		wr(A_C, 32'h8a);
		meas(hi, per);
		meas(hi, per);
		chk("live_high", exp_hi(3, 2, 1), hi);
		while (pin !== 1'b1) @(posedge clk);
		chk("internal_high", 1, pin_int);
		wr(A_C, 32'h1a);
		// second settled point after the write lands, still inside the high time
		repeat (2) @(negedge clk);
		chk("stop_now", 0, pin);
		chk("internal_stop", 0, pin_int);
		@(posedge clk);
		for (int c = 0; c < 16; c++) begin
			wr(A_C, 32'h0);
			wr(A_S, c);
			wr(A_C, 32'h90);
			rises(n);
			chk("src_runs", c < 11, n > 0);
		end
		sleep_mode <= 1'b1;
		wr(A_S, 32'h2);
		rises(n);
		chk("sleep_osc", 1, n > 0);
		wr(A_S, 32'h0);
		rises(n);
		chk("sleep_main", 0, n);
		rdc("status_sleep", A_T, 32'h0);
		sleep_mode <= 1'b0;
		conclude();
	end
endmodule : tb_rco_top
`default_nettype wire
